// *** plm_map.svh ***
`ifndef PLM_MAP_SVH
`define PLM_MAP_SVH
`define PLM_A_CTRL 8'h00
`define PLM_A_NODE 8'h04
`define PLM_A_OUTS 8'h08
`define PLM_A_THR0 8'h0C
`define PLM_A_WIN0 8'h10
`define PLM_A_THR1 8'h14
`define PLM_A_WIN1 8'h18
`define PLM_A_FACC0 8'h1C
`define PLM_A_TOT0 8'h20
`define PLM_A_FACC1 8'h24
`define PLM_A_TOT1 8'h28
`define PLM_A_IRQ_ST 8'h2C
`define PLM_A_IRQ_MSK 8'h30
`define PLM_A_STAT 8'h34
`define PLM_A_FAIL0 8'h38
`define PLM_A_FAIL1 8'h3C
`define PLM_CTRL_RATE 0
`define PLM_CTRL_XOVER 1
`define PLM_CRC_POLY 32'h04C1_1DB7
`define PLM_CRC_INIT 32'hFFFF_FFFF
`define PLM_CRC_FIRST 5'h10
`define PLM_LAST_IDX 5'h13
`define PLM_KIND_INTEG 8'h01
`define PLM_KIND_CHANGE 8'h02
`define PLM_CLK_KHZ 10000
`define PLM_LO_KBPS 64
`define PLM_HI_KBPS 128
`define PLM_INTEG_LO_MS 1000
`define PLM_INTEG_HI_MS 500
`endif

// *** plm_pkg.sv ***
package plm_pkg;
`include "plm_map.svh"

  typedef enum logic {TX_IDLE, TX_SEND} plm_tx_st_t;

  typedef struct packed {
    logic [4:0]  idx;
    logic [31:0] crc;
    logic [31:0] rx_crc;
    logic [15:0] total;
    logic [15:0] fail;
    logic [15:0] fail_acc;
    logic        alarm;
    logic        done;
    logic        ok;
  } plm_mon_st_t;

  typedef struct packed {
    logic             rate_hi;
    logic             xover;
    logic [7:0]       node_id;
    logic [31:0]      out_state;
    logic [1:0][15:0] thr;
    logic [1:0][15:0] win;
    logic [3:0]       irq_st;
    logic [3:0]       irq_mask;
    logic [31:0]      rdata;
    logic [1:0]       alarm_q;
    logic [1:0]       rx_in;
    logic [1:0]       fwd_on;
    plm_tx_st_t       tx_st;
    logic [4:0]       tx_idx;
    logic [10:0]      byte_tmr;
    logic [23:0]      integ_tmr;
    logic             chg_pend;
    logic             integ_pend;
    logic [7:0]       tx_kind;
    logic [31:0]      tx_crc;
    logic [31:0]      tx_snap;
    logic [1:0]       tx_valid;
    logic [1:0][7:0]  tx_data;
    logic [1:0]       tx_last;
  } plm_top_st_t;

  // MSB-first CRC-32 update over one byte
  function automatic logic [31:0] plm_crc8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ b[i]) ? ({r[30:0], 1'b0} ^ `PLM_CRC_POLY) : {r[30:0], 1'b0};
    end
    return r;
  endfunction
endpackage

// *** plm_mon_if.sv ***
`timescale 1ns/1ps
interface plm_mon_if;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_last;
  logic [15:0] thr;
  logic [15:0] win;
  logic [15:0] total;
  logic [15:0] fail;
  logic [15:0] fail_acc;
  logic        alarm;
  logic        done;
  logic        ok;
  modport mon (input rx_valid, rx_data, rx_last, thr, win,
               output total, fail, fail_acc, alarm, done, ok);
  modport top (output rx_valid, rx_data, rx_last, thr, win,
               input total, fail, fail_acc, alarm, done, ok);
endinterface

// *** plm_chan_mon.sv ***
`timescale 1ns/1ps
module plm_chan_mon
  import plm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  plm_mon_if.mon   m
);
  plm_mon_st_t s_r;
  plm_mon_st_t s_nxt;
  logic [15:0] tot_n;
  logic [15:0] fail_n;
  logic        good;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    tot_n = s_r.total + 16'h0001;
    // Check bytes arrive MSB first: three shifted in, the last one on the bus
    good = (s_r.idx == `PLM_LAST_IDX) && (m.rx_data == s_r.crc[7:0]) &&
           (s_r.rx_crc[23:0] == s_r.crc[31:8]);
    fail_n = s_r.fail + {15'h0000, ~good};
    if (m.rx_valid) begin
      if (s_r.idx < `PLM_CRC_FIRST) begin
        s_nxt.crc = plm_crc8(s_r.crc, m.rx_data);
      end else begin
        s_nxt.rx_crc = {s_r.rx_crc[23:0], m.rx_data};
      end
      s_nxt.idx = (s_r.idx == 5'h1F) ? s_r.idx : s_r.idx + 5'h01;
      if (m.rx_last) begin
        // A short or long frame is counted as a failure
        s_nxt.done = 1'b1;
        s_nxt.ok = good;
        s_nxt.idx = 5'h00;
        s_nxt.crc = `PLM_CRC_INIT;
        s_nxt.rx_crc = 32'h0000_0000;
        s_nxt.total = tot_n;
        s_nxt.fail = fail_n;
        if (!good) begin
          s_nxt.fail_acc = s_r.fail_acc + 16'h0001;
        end
        if (m.thr != 16'h0000 && fail_n >= m.thr) begin
          s_nxt.alarm = 1'b1;
        end
        if (tot_n >= m.win) begin
          s_nxt.total = 16'h0000;
          s_nxt.fail = 16'h0000;
          s_nxt.alarm = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.crc <= `PLM_CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign m.total = s_r.total;
  assign m.fail = s_r.fail;
  assign m.fail_acc = s_r.fail_acc;
  assign m.alarm = s_r.alarm;
  assign m.done = s_r.done;
  assign m.ok = s_r.ok;
endmodule

// *** plm_top.sv ***
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module plm_top
  import plm_pkg::*;
#(
  parameter int unsigned INTEG_LO_CYC = `PLM_INTEG_LO_MS * `PLM_CLK_KHZ,
  parameter int unsigned INTEG_HI_CYC = `PLM_INTEG_HI_MS * `PLM_CLK_KHZ
)(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic [7:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [31:0]     rdata,
  output logic                 irq,
  input  wire logic [1:0]      media_fixed,
  input  wire logic [1:0]      rx_valid,
  input  wire logic [1:0][7:0] rx_data,
  input  wire logic [1:0]      rx_last,
  output logic      [1:0]      tx_valid,
  output logic      [1:0][7:0] tx_data,
  output logic      [1:0]      tx_last,
  output logic      [1:0]      check_fail_alarm_flag
);
  // Byte slot on the link: eight bit times at the active rate
  localparam int unsigned BYTE_LO_CYC = 8 * `PLM_CLK_KHZ / `PLM_LO_KBPS;
  localparam int unsigned BYTE_HI_CYC = 8 * `PLM_CLK_KHZ / `PLM_HI_KBPS;

  plm_top_st_t      s_r;
  plm_top_st_t      s_nxt;
  logic [1:0]       mon_done;
  logic [1:0]       mon_ok;
  logic [1:0]       mon_alarm;
  logic [1:0][15:0] mon_total;
  logic [1:0][15:0] mon_fail;
  logic [1:0][15:0] mon_facc;
  logic             rate_eff;
  logic [3:0]       irq_ev;
  logic [31:0]      rd_val;
  logic [7:0]       own_byte;
  logic             fwd_start_any;
  logic [1:0]       fwd_start;
  logic [1:0]       src_of;

  ////////////////////////////////////////////////////////////////////////////
  // One monitor per channel
  plm_mon_if mif[2] ();

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      assign mif[ch].rx_valid = rx_valid[ch];
      assign mif[ch].rx_data = rx_data[ch];
      assign mif[ch].rx_last = rx_last[ch];
      assign mif[ch].thr = s_r.thr[ch];
      assign mif[ch].win = s_r.win[ch];
      assign mon_done[ch] = mif[ch].done;
      assign mon_ok[ch] = mif[ch].ok;
      assign mon_alarm[ch] = mif[ch].alarm;
      assign mon_total[ch] = mif[ch].total;
      assign mon_fail[ch] = mif[ch].fail;
      assign mon_facc[ch] = mif[ch].fail_acc;
      plm_chan_mon u_mon (
        .clk   (clk),
        .reset (reset),
        .m     (mif[ch].mon)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register decode shared by read path
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `PLM_A_CTRL: begin
        v[`PLM_CTRL_RATE] = s_r.rate_hi;
        v[`PLM_CTRL_XOVER] = s_r.xover;
      end
      `PLM_A_NODE: v[7:0] = s_r.node_id;
      `PLM_A_OUTS: v = s_r.out_state;
      `PLM_A_THR0: v[15:0] = s_r.thr[0];
      `PLM_A_WIN0: v[15:0] = s_r.win[0];
      `PLM_A_THR1: v[15:0] = s_r.thr[1];
      `PLM_A_WIN1: v[15:0] = s_r.win[1];
      `PLM_A_FACC0: v[15:0] = mon_facc[0];
      `PLM_A_TOT0: v[15:0] = mon_total[0];
      `PLM_A_FACC1: v[15:0] = mon_facc[1];
      `PLM_A_TOT1: v[15:0] = mon_total[1];
      `PLM_A_FAIL0: v[15:0] = mon_fail[0];
      `PLM_A_FAIL1: v[15:0] = mon_fail[1];
      `PLM_A_IRQ_ST: v[3:0] = s_r.irq_st;
      `PLM_A_IRQ_MSK: v[3:0] = s_r.irq_mask;
      `PLM_A_STAT: v[6:0] = {s_r.fwd_on, s_r.tx_st == TX_SEND, rate_eff, mon_alarm, 1'b0};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Byte of our own frame at a given position
  function automatic logic [7:0] frame_byte(input logic [4:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      5'h00: b = s_r.node_id;
      5'h01: b = s_r.tx_kind;
      5'h02: b = s_r.tx_snap[31:24];
      5'h03: b = s_r.tx_snap[23:16];
      5'h04: b = s_r.tx_snap[15:8];
      5'h05: b = s_r.tx_snap[7:0];
      default: b = (i >= `PLM_CRC_FIRST) ? s_r.tx_crc[31:24] : 8'h00;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Fixed media pins force the shared rate low for both channels
  assign rate_eff = s_r.rate_hi & ~(|media_fixed);
  // Both functions read state beyond their arguments, so a process keeps them current
  always_comb begin
    rd_val = reg_read(addr);
    own_byte = frame_byte(s_r.tx_idx);
  end

  // With crossover each channel relays what the other one received
  assign src_of[0] = s_r.xover;
  assign src_of[1] = ~s_r.xover;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // Foreign frames are relayed only while our own frame is not on the wire
      fwd_start[c] = rx_valid[c] && !s_r.rx_in[c] &&
                     (rx_data[c] != s_r.node_id) && (s_r.tx_st == TX_IDLE);
    end
    fwd_start_any = |fwd_start;
  end

  assign irq_ev = {mon_done & ~mon_ok, mon_alarm & ~s_r.alarm_q};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.alarm_q = mon_alarm;
    s_nxt.rdata = 32'h0000_0000;
    s_nxt.tx_valid = 2'b00;
    s_nxt.tx_last = 2'b00;

    // Register bus
    if (rd) begin
      s_nxt.rdata = rd_val;
    end
    if (wr) begin
      case (addr)
        `PLM_A_CTRL: begin
          s_nxt.rate_hi = wdata[`PLM_CTRL_RATE];
          s_nxt.xover = wdata[`PLM_CTRL_XOVER];
        end
        `PLM_A_NODE: s_nxt.node_id = wdata[7:0];
        `PLM_A_OUTS: begin
          s_nxt.out_state = wdata;
          if (wdata != s_r.out_state) begin
            s_nxt.chg_pend = 1'b1;
          end
        end
        `PLM_A_THR0: s_nxt.thr[0] = wdata[15:0];
        `PLM_A_WIN0: s_nxt.win[0] = wdata[15:0];
        `PLM_A_THR1: s_nxt.thr[1] = wdata[15:0];
        `PLM_A_WIN1: s_nxt.win[1] = wdata[15:0];
        `PLM_A_IRQ_ST: s_nxt.irq_st = s_r.irq_st & ~wdata[3:0];
        `PLM_A_IRQ_MSK: s_nxt.irq_mask = wdata[3:0];
        default: s_nxt.irq_mask = s_nxt.irq_mask;
      endcase
    end
    // New events win over a same-cycle clear
    s_nxt.irq_st = s_nxt.irq_st | irq_ev;

    // Integrity tick, period follows the shared rate
    if (s_r.integ_tmr == 24'h00_0000) begin
      s_nxt.integ_pend = 1'b1;
      s_nxt.integ_tmr = rate_eff ? 24'(INTEG_HI_CYC - 1) : 24'(INTEG_LO_CYC - 1);
    end else begin
      s_nxt.integ_tmr = s_r.integ_tmr - 24'h00_0001;
    end

    // Receive frame tracking and relay
    for (int c = 0; c < 2; c++) begin
      if (rx_valid[c]) begin
        s_nxt.rx_in[c] = !rx_last[c];
        if (fwd_start[c]) begin
          s_nxt.fwd_on[c] = !rx_last[c];
        end else if (rx_last[c]) begin
          s_nxt.fwd_on[c] = 1'b0;
        end
      end
    end
    for (int d = 0; d < 2; d++) begin
      // Cut-through relay keeps per-hop delay to one clock cycle
      if (rx_valid[src_of[d]] && (s_r.fwd_on[src_of[d]] || fwd_start[src_of[d]])) begin
        s_nxt.tx_valid[d] = 1'b1;
        s_nxt.tx_data[d] = rx_data[src_of[d]];
        s_nxt.tx_last[d] = rx_last[src_of[d]];
      end
    end

    // Own frame, sent on both channels at once
    case (s_r.tx_st)
      TX_IDLE: begin
        if ((s_r.integ_pend || s_r.chg_pend) && s_r.fwd_on == 2'b00 && !fwd_start_any) begin
          s_nxt.tx_st = TX_SEND;
          s_nxt.tx_idx = 5'h00;
          s_nxt.byte_tmr = 11'h000;
          s_nxt.tx_kind = s_r.chg_pend ? `PLM_KIND_CHANGE : `PLM_KIND_INTEG;
          s_nxt.tx_snap = s_r.out_state;
          s_nxt.tx_crc = `PLM_CRC_INIT;
          // A change written in the start cycle stays queued for the next frame
          s_nxt.chg_pend = wr && (addr == `PLM_A_OUTS) && (wdata != s_r.out_state);
          s_nxt.integ_pend = (s_r.integ_tmr == 24'h00_0000);
        end
      end
      TX_SEND: begin
        if (s_r.byte_tmr == 11'h000) begin
          s_nxt.tx_valid = 2'b11;
          s_nxt.tx_data = {own_byte, own_byte};
          s_nxt.byte_tmr = rate_eff ? 11'(BYTE_HI_CYC - 1) : 11'(BYTE_LO_CYC - 1);
          if (s_r.tx_idx < `PLM_CRC_FIRST) begin
            s_nxt.tx_crc = plm_crc8(s_r.tx_crc, own_byte);
          end else begin
            s_nxt.tx_crc = {s_r.tx_crc[23:0], 8'h00};
          end
          s_nxt.tx_idx = s_r.tx_idx + 5'h01;
          if (s_r.tx_idx == `PLM_LAST_IDX) begin
            s_nxt.tx_last = 2'b11;
            s_nxt.tx_st = TX_IDLE;
          end
        end else begin
          s_nxt.byte_tmr = s_r.byte_tmr - 11'h001;
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.tx_st <= TX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign irq = |(s_r.irq_st & s_r.irq_mask);
  assign tx_valid = s_r.tx_valid;
  assign tx_data = s_r.tx_data;
  assign tx_last = s_r.tx_last;
  assign check_fail_alarm_flag = mon_alarm;
endmodule

// *** plm_top_assertions.sv ***
`timescale 1ns/1ps
module plm_top_assertions
  import plm_pkg::*;
#(
  parameter int unsigned INTEG_LO_CYC = 20000
)(
  input wire logic            clk,
  input wire logic            reset,
  input wire logic [7:0]      addr,
  input wire logic            wr,
  input wire logic            rd,
  input wire logic [31:0]     rdata,
  input wire logic            irq,
  input wire logic [1:0]      rx_valid,
  input wire logic [1:0]      rx_last,
  input wire logic [1:0]      tx_valid,
  input wire logic [1:0]      tx_last,
  input wire logic [1:0]      check_fail_alarm_flag
);
  ////////////////////////////////////////////////////////////
  // Frame-end history per channel, so alarm rises and channel 0 alarm falls can be traced to a frame; gap_r times channel 0 transmit silence
  logic [2:0]  h0_r;
  logic [2:0]  h1_r;
  logic [31:0] gap_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      h0_r  <= 3'h0;
      h1_r  <= 3'h0;
      gap_r <= 32'h0;
    end else begin
      h0_r  <= {h0_r[1:0], rx_valid[0] & rx_last[0]};
      h1_r  <= {h1_r[1:0], rx_valid[1] & rx_last[1]};
      gap_r <= tx_valid[0] ? 32'h0 : gap_r + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_unmapped_read: assert property (rd && addr > 8'h3C |=> rdata == 32'h0)
    else $error("unmapped read returned data");
  a_alarm0_rise_cause: assert property ($rose(check_fail_alarm_flag[0]) |-> h0_r[1:0] != 2'b00)
    else $error("channel 0 alarm rose without a frame end");
  a_alarm1_rise_cause: assert property ($rose(check_fail_alarm_flag[1]) |-> h1_r[1:0] != 2'b00)
    else $error("channel 1 alarm rose without a frame end");
  a_alarm0_hold: assert property ($fell(check_fail_alarm_flag[0]) |-> h0_r[1:0] != 2'b00)
    else $error("channel 0 alarm dropped outside a window restart");
  a_irq_change_cause: assert property ($changed(irq) |-> $past(wr) || $past(wr, 2) || (h0_r | h1_r) != 3'h0)
    else $error("interrupt changed without write or frame");
  a_tx_last_valid: assert property ((tx_last & ~tx_valid) == 2'b00)
    else $error("frame end marker without byte");
  a_first_integ_frame: assert property ($past(reset) |-> ##[0:4] tx_valid == 2'b11)
    else $error("no integrity frame after reset");
  a_integ_gap_bound: assert property (gap_r <= INTEG_LO_CYC + 32'd1300)
    else $error("transmit silent longer than integrity period");
endmodule

bind plm_top plm_top_assertions #(.INTEG_LO_CYC(INTEG_LO_CYC)) chk_u (
  .clk(clk), .reset(reset), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
  .rx_valid(rx_valid), .rx_last(rx_last), .tx_valid(tx_valid), .tx_last(tx_last),
  .check_fail_alarm_flag(check_fail_alarm_flag));

// *** plm_peer_model.sv ***
`timescale 1ns/1ps
`include "plm_map.svh"
module plm_peer_model (
  output logic      [1:0]      rx_valid,
  output logic      [1:0][7:0] rx_data,
  output logic      [1:0]      rx_last,
  input  wire logic            clk,
  input  wire logic [1:0]      tx_valid,
  input  wire logic [1:0][7:0] tx_data,
  input  wire logic [1:0]      tx_last
);
  logic [7:0] cap [2][20];
  int         cnt [2]    = '{0, 0};
  int         len [2]    = '{0, 0};
  int         frames [2] = '{0, 0};
  initial begin
    rx_valid = 2'b00;
    rx_last  = 2'b00;
    rx_data  = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = (c[31] ^ b[i]) ? {c[30:0], 1'b0} ^ `PLM_CRC_POLY : {c[30:0], 1'b0};
    return c;
  endfunction
  function automatic bit crc_ok(input int ch);
    logic [31:0] c;
    c = `PLM_CRC_INIT;
    for (int i = 0; i < 16; i++) c = crc_step(c, cap[ch][i]);
    return c === {cap[ch][16], cap[ch][17], cap[ch][18], cap[ch][19]};
  endfunction
  ////////////////////////////////////////////////////////////
  // Sink keeps the latest frame per channel; modulo guards against runaway frames
  always @(posedge clk) begin
    for (int ch = 0; ch < 2; ch++) begin
      if (tx_valid[ch] === 1'b1) begin
        cap[ch][cnt[ch] % 20] <= tx_data[ch];
        cnt[ch] <= tx_last[ch] ? 0 : cnt[ch] + 1;
        if (tx_last[ch]) begin
          len[ch]    <= cnt[ch] + 1;
          frames[ch] <= frames[ch] + 1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // Source: 20-byte frame, gap+1 idles between bytes when gap is nonzero; idle data is inverted, never held
  task automatic send(input int ch, input logic [7:0] id, input bit bad, input int gap);
    logic [7:0]  b [20];
    logic [31:0] c;
    c = `PLM_CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      b[i] = (i == 0) ? id : 8'(i * 17);
      c    = crc_step(c, b[i]);
    end
    c[0] = c[0] ^ bad;
    for (int i = 0; i < 4; i++) b[16 + i] = c[31 - 8 * i -: 8];
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      rx_valid[ch] <= 1'b1;
      rx_data[ch]  <= b[i];
      rx_last[ch]  <= (i == 19);
      if (gap > 0 || i == 19) begin
        @(posedge clk);
        rx_valid[ch] <= 1'b0;
        rx_last[ch]  <= 1'b0;
        rx_data[ch]  <= ~b[i];
        repeat (gap) @(posedge clk);
      end
    end
  endtask
endmodule

// *** tb_peer_link_crc_monitor.sv ***
`timescale 1ns/1ps
`include "plm_map.svh"
module tb_peer_link_crc_monitor;
  logic            clk;
  logic            reset;
  logic            wr;
  logic            rd;
  logic            irq;
  logic [7:0]      addr;
  logic [31:0]     wdata;
  logic [31:0]     rdata;
  logic [1:0]      media_fixed;
  logic [1:0]      rx_valid;
  logic [1:0]      rx_last;
  logic [1:0]      tx_valid;
  logic [1:0]      tx_last;
  logic [1:0]      alarm;
  logic [1:0][7:0] rx_data;
  logic [1:0][7:0] tx_data;
  int              error_cnt = 0;
  int              cmp_count = 0;

  // Long periods so a change frame fits between integrity frames
  plm_top #(.INTEG_LO_CYC(80000), .INTEG_HI_CYC(40000)) dut_u (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .media_fixed(media_fixed), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .check_fail_alarm_flag(alarm));
  plm_peer_model peer_u (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask
  task settle;
    repeat (3) @(negedge clk);
  endtask
  task wait_frm(input int ch, input int n);
    for (int i = 0; i < 30000 && peer_u.frames[ch] < n; i++) @(posedge clk);
    chk(peer_u.frames[ch], n);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    reset       = 1'b1;
    wr          = 1'b0;
    rd          = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h0000_0000;
    media_fixed = 2'b00;
    repeat (4) @(posedge clk);
    reset       <= 1'b0;
    media_fixed <= 2'b01;
    wr32(`PLM_A_CTRL, 32'h0000_0001);
    rchk(`PLM_A_STAT, 32'h0000_0000, 32'h0000_0008);
    @(posedge clk);
    media_fixed <= 2'b00;
    rchk(`PLM_A_STAT, 32'h0000_0008, 32'h0000_0008);
    wr32(8'hF0, 32'hFFFF_FFFF);
    rchk(8'hF0, 32'h0000_0000);
    // Channel 0: threshold 2 in a window of 4
    wr32(`PLM_A_THR0, 32'h0000_0002);
    wr32(`PLM_A_WIN0, 32'h0000_0004);
    peer_u.send(0, 8'h33, 1'b0, 0);
    peer_u.send(0, 8'h33, 1'b1, 2);
    rchk(`PLM_A_TOT0, 32'h0000_0002);
    rchk(`PLM_A_FAIL0, 32'h0000_0001);
    chk({30'h0, alarm}, 32'h0000_0000);
    peer_u.send(0, 8'h33, 1'b1, 0);
    settle;
    chk({30'h0, alarm}, 32'h0000_0001);
    rchk(`PLM_A_IRQ_ST, 32'h0000_0005, 32'h0000_000F);
    chk({31'h0, irq}, 32'h0000_0000);
    wr32(`PLM_A_IRQ_MSK, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr32(`PLM_A_IRQ_ST, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`PLM_A_IRQ_ST, 32'h0000_0004, 32'h0000_000F);
    chk({30'h0, alarm}, 32'h0000_0001);
    peer_u.send(0, 8'h33, 1'b0, 0);
    settle;
    chk({30'h0, alarm}, 32'h0000_0000);
    rchk(`PLM_A_TOT0, 32'h0000_0000);
    rchk(`PLM_A_FAIL0, 32'h0000_0000);
    rchk(`PLM_A_FACC0, 32'h0000_0002);
    // Channel 1 runs its own monitor
    wr32(`PLM_A_THR1, 32'h0000_0001);
    wr32(`PLM_A_WIN1, 32'h0000_0010);
    peer_u.send(1, 8'h44, 1'b1, 0);
    settle;
    chk({30'h0, alarm}, 32'h0000_0002);
    rchk(`PLM_A_FACC1, 32'h0000_0001);
    rchk(`PLM_A_TOT0, 32'h0000_0000);
    // First integrity frame on both channels
    wait_frm(0, 1);
    wait_frm(1, 1);
    chk(peer_u.len[0], 20);
    chk({24'h0, peer_u.cap[0][1]}, {24'h0, `PLM_KIND_INTEG});
    chk({31'h0, peer_u.crc_ok(0)}, 32'h0000_0001);
    // Foreign frame crosses to channel 1, own-id frame is dropped
    wr32(`PLM_A_NODE, 32'h0000_005A);
    wr32(`PLM_A_CTRL, 32'h0000_0003);
    peer_u.send(0, 8'h33, 1'b0, 0);
    // Cut-through relay: the last byte leaves one cycle after it arrives
    repeat (2) @(negedge clk);
    chk(peer_u.frames[1], 2);
    wait_frm(1, 2);
    chk({24'h0, peer_u.cap[1][0]}, 32'h0000_0033);
    peer_u.send(0, 8'h5A, 1'b0, 0);
    repeat (40) @(posedge clk);
    chk(peer_u.frames[1], 2);
    // Output change sends an extra frame with our identity
    wr32(`PLM_A_OUTS, 32'h1234_5678);
    wait_frm(0, 2);
    chk({24'h0, peer_u.cap[0][0]}, 32'h0000_005A);
    chk({24'h0, peer_u.cap[0][1]}, {24'h0, `PLM_KIND_CHANGE});
    chk({peer_u.cap[0][2], peer_u.cap[0][3], peer_u.cap[0][4], peer_u.cap[0][5]},
        32'h1234_5678);
    chk({31'h0, peer_u.crc_ok(0)}, 32'h0000_0001);
    report_and_stop;
  end
endmodule
